// ===== logic/lfcs_top.sv
// lfcs_top: apb register file for low-frequency branch source selection and the
// read-only oscillator status register; drives the two branch clocks.
// assumes an apb master on pclk and live oscillator status synchronous to pclk.
// assumes software writes reserved select bits as zero; they are dropped regardless.
//
// Functional notes
// (RULE_01) B field 0 off, 1 slow rc
// (RULE_02) B field 2 selects slow crystal
// (RULE_03) B field 3 selects core clock half
// (RULE_04) B field bits 1:0, A bits 3:2
// (RULE_05) A field 0 off, 1 slow rc
// (RULE_06) A field 2 selects slow crystal
// (RULE_07) A field 3 selects core clock half
// (RULE_08) A field 0 plus extension: ultra slow
// (RULE_09) B extension bit 20 picks ultra slow
// (RULE_10) status read-only, live, fast rc set
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lfcs_top
    import lfcs_pkg::*;
(
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // apb slave
    input  wire logic [LFCS_ADDR_W-1:0]   paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // oscillator sources and live status
    input  wire logic                     slow_rc_oscillator,
    input  wire logic                     slow_crystal_oscillator,
    input  wire logic                     ultra_slow_rc_oscillator,
    input  wire logic                     le_core_clock,
    input  wire logic [LFCS_STATUS_W-1:0] osc_status_live,
    // branch clocks
    output logic                          branch_a_slow_clock,
    output logic                          branch_b_slow_clock
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        // select register
        logic [1:0]               branch_a_source_field;
        logic                     branch_a_extension_bit;
        logic [1:0]               branch_b_source_field;
        logic                     branch_b_extension_bit;
        // live status mirror
        logic [LFCS_STATUS_W-1:0] status;
        // apb answer
        logic [31:0]              rdata;
        logic                     ready;
        logic                     err;
    } lfcs_top_t;

    lfcs_top_t st;
    lfcs_top_t next_st;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic lfcs_hit_select(input logic [LFCS_ADDR_W-1:0] a);
        return a == LFCS_OFF_SELECT;
    endfunction : lfcs_hit_select

    function automatic logic lfcs_hit_status(input logic [LFCS_ADDR_W-1:0] a);
        return a == LFCS_OFF_STATUS;
    endfunction : lfcs_hit_status

    // only the two word offsets decode; anything else is refused with an error
    function automatic logic lfcs_mapped(input logic [LFCS_ADDR_W-1:0] a);
        return lfcs_hit_select(a) || lfcs_hit_status(a);
    endfunction : lfcs_mapped

    ////////////////////////////////////////////////////////////////////////////////
    // register images

    // select word: fields in place, reserved bits read as zero
    function automatic logic [31:0] lfcs_select_word(input lfcs_top_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[LFCS_B_SRC_LSB +: 2] = s.branch_b_source_field; // RULE_04
        v[LFCS_A_SRC_LSB +: 2] = s.branch_a_source_field; // RULE_04
        v[LFCS_A_EXT_BIT]      = s.branch_a_extension_bit; // RULE_08
        v[LFCS_B_EXT_BIT]      = s.branch_b_extension_bit; // RULE_09
        return v;
    endfunction : lfcs_select_word

    // status word: live bits low, the upper bits reserved and read as zero
    function automatic logic [31:0] lfcs_status_word(input lfcs_top_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[LFCS_STATUS_W-1:0] = s.status; // RULE_10
        return v;
    endfunction : lfcs_status_word

    function automatic logic [31:0] lfcs_read(input lfcs_top_t s, input logic [LFCS_ADDR_W-1:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (lfcs_hit_select(a)) begin
            v = lfcs_select_word(s);
        end else if (lfcs_hit_status(a)) begin
            v = lfcs_status_word(s);
        end
        return v;
    endfunction : lfcs_read

    // merge one write into the select fields; a lane with its strobe low keeps its bits
    function automatic lfcs_top_t lfcs_write(input lfcs_top_t s, input logic [31:0] d, input logic [3:0] strb);
        lfcs_top_t r;
        r = s;
        if (strb[0]) begin
            r.branch_b_source_field = d[LFCS_B_SRC_LSB +: 2]; // RULE_04
            r.branch_a_source_field = d[LFCS_A_SRC_LSB +: 2]; // RULE_04
        end
        if (strb[2]) begin
            r.branch_a_extension_bit = d[LFCS_A_EXT_BIT]; // RULE_08
            r.branch_b_extension_bit = d[LFCS_B_EXT_BIT]; // RULE_09
        end
        return r;
    endfunction : lfcs_write

    ////////////////////////////////////////////////////////////////////////////////
    // apb phases

    // pready is high in every access cycle once out of reset, so no wait state is counted
    logic apb_setup;
    logic apb_access;

    assign apb_setup  = psel && !penable;
    assign apb_access = psel && penable;

    ////////////////////////////////////////////////////////////////////////////////
    // register file

    always_comb begin
        next_st        = st;
        next_st.ready  = 1'b1;
        // status mirrors the oscillators one cycle late; software cannot touch it
        next_st.status = osc_status_live; // RULE_10
        // read data and error are prepared in the setup cycle for a zero-wait answer
        if (apb_setup) begin
            next_st.rdata = lfcs_read(st, paddr);
            next_st.err   = !lfcs_mapped(paddr);
        end
        // a write lands only at the access edge; writes to status are ignored
        if (apb_access && pwrite && lfcs_hit_select(paddr)) begin
            next_st = lfcs_write(next_st, pwdata, pstrb);
        end
        if (apb_access) begin
            next_st.err = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // both branches leave reset on the slow rc with their extensions clear
            st.branch_a_source_field  <= LFCS_SRC_RESET;
            st.branch_a_extension_bit <= LFCS_EXT_RESET;
            st.branch_b_source_field  <= LFCS_SRC_RESET;
            st.branch_b_extension_bit <= LFCS_EXT_RESET; // RULE_09
            st.status                 <= LFCS_STATUS_RESET; // RULE_10
            st.rdata                  <= 32'h0000_0000;
            st.ready                  <= 1'b0;
            st.err                    <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    // the error flag is cleared after the access edge, so it stands only in the access cycle
    assign prdata  = st.rdata;
    assign pready  = st.ready;
    assign pslverr = st.err;

    ////////////////////////////////////////////////////////////////////////////////
    // branch selectors

    // a new source is taken at the next pclk edge with no handover between running
    // oscillators, so software should stop the branch's users before switching
    lfcs_sel_if sel_a ();
    lfcs_sel_if sel_b ();

    assign sel_a.src = st.branch_a_source_field;
    assign sel_a.ext = st.branch_a_extension_bit;
    assign sel_b.src = st.branch_b_source_field;
    assign sel_b.ext = st.branch_b_extension_bit;

    lfcs_branch u_branch_a (
        .pclk                     (pclk),
        .presetn                  (presetn),
        .cfg                      (sel_a),
        .slow_rc_oscillator       (slow_rc_oscillator),
        .slow_crystal_oscillator  (slow_crystal_oscillator),
        .ultra_slow_rc_oscillator (ultra_slow_rc_oscillator),
        .le_core_clock            (le_core_clock),
        .slow_clock               (branch_a_slow_clock)
    );

    lfcs_branch u_branch_b (
        .pclk                     (pclk),
        .presetn                  (presetn),
        .cfg                      (sel_b),
        .slow_rc_oscillator       (slow_rc_oscillator),
        .slow_crystal_oscillator  (slow_crystal_oscillator),
        .ultra_slow_rc_oscillator (ultra_slow_rc_oscillator),
        .le_core_clock            (le_core_clock),
        .slow_clock               (branch_b_slow_clock)
    );

endmodule : lfcs_top
`default_nettype wire

// ===== logic/lfcs_pkg.sv
// lfcs_pkg: register map, field layout, reset values and source decode of the
// low-frequency clock select block.
// assumes an apb slave with 32-bit data and one aligned word per register.
package lfcs_pkg;

    localparam int unsigned   LFCS_ADDR_W         = 12;
    localparam logic [11:0]   LFCS_OFF_SELECT     = 12'h028;
    localparam logic [11:0]   LFCS_OFF_STATUS     = 12'h02C;

    // select register field positions
    localparam int unsigned   LFCS_B_SRC_LSB      = 0;
    localparam int unsigned   LFCS_A_SRC_LSB      = 2;
    localparam int unsigned   LFCS_A_EXT_BIT      = 16;
    localparam int unsigned   LFCS_B_EXT_BIT      = 20;

    localparam logic [1:0]    LFCS_SRC_RESET      = 2'h1;
    localparam logic          LFCS_EXT_RESET      = 1'h0;

    // source field encodings
    localparam logic [1:0]    LFCS_SRC_OFF        = 2'h0;
    localparam logic [1:0]    LFCS_SRC_RC         = 2'h1;
    localparam logic [1:0]    LFCS_SRC_XTAL       = 2'h2;
    localparam logic [1:0]    LFCS_SRC_HALF       = 2'h3;

    // status register: 15 live bits, fast rc selected/ready/enabled out of reset
    localparam int unsigned   LFCS_STATUS_W       = 15;
    localparam logic [14:0]   LFCS_STATUS_RESET   = 15'h0403;

    // pick the branch clock level from the field, its extension bit and the sources
    function automatic logic lfcs_pick(
        input logic [1:0] src,
        input logic       ext,
        input logic       rc,
        input logic       xtal,
        input logic       half,
        input logic       ultra
    );
        logic r;
        r = 1'b0;
        case (src)
            LFCS_SRC_OFF:  r = ext ? ultra : 1'b0; // RULE_01 RULE_05 RULE_08 RULE_09
            LFCS_SRC_RC:   r = rc;                 // RULE_01 RULE_05
            LFCS_SRC_XTAL: r = xtal;               // RULE_02 RULE_06
            LFCS_SRC_HALF: r = half;               // RULE_03 RULE_07
            default:       r = 1'b0;
        endcase
        return r;
    endfunction : lfcs_pick

endpackage : lfcs_pkg

// ===== logic/lfcs_sel_if.sv
// lfcs_sel_if: carries one branch's source field and extension bit from the
// register file to the branch selector.
// assumes both ends run on the same pclk.
`timescale 1ns/10ps
`default_nettype none
interface lfcs_sel_if;
    logic [1:0] src;
    logic       ext;

    modport ctrl (output src, output ext);
    modport sel  (input src, input ext);
endinterface : lfcs_sel_if
`default_nettype wire

// ===== logic/lfcs_branch.sv
// lfcs_branch: selects the source of one low-frequency branch and registers it.
// assumes source clocks are far slower than pclk and sampled as plain levels.
`timescale 1ns/10ps
`default_nettype none
module lfcs_branch
    import lfcs_pkg::*;
(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // selection from the register file
    lfcs_sel_if.sel   cfg,
    // source levels
    input  wire logic slow_rc_oscillator,
    input  wire logic slow_crystal_oscillator,
    input  wire logic ultra_slow_rc_oscillator,
    input  wire logic le_core_clock,
    // selected branch clock
    output logic      slow_clock
);

    typedef struct packed {
        logic le_prev;
        logic half;
        logic out;
    } lfcs_branch_t;

    lfcs_branch_t st;
    lfcs_branch_t next_st;

    always_comb begin
        next_st         = st;
        next_st.le_prev = le_core_clock;
        // divide by two: toggle on each rising edge of the core clock level
        if (le_core_clock && !st.le_prev) begin
            next_st.half = ~st.half; // RULE_03 RULE_07
        end
        // registered output trades one pclk of latency for a glitch-free branch
        next_st.out = lfcs_pick(cfg.src, cfg.ext, slow_rc_oscillator, slow_crystal_oscillator,
                                st.half, ultra_slow_rc_oscillator);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign slow_clock = st.out;

endmodule : lfcs_branch
`default_nettype wire

// ===== verification/lfcs_top_chk.sv
// lfcs_top_chk: port assertions for lfcs_top.
// assumes one pclk domain; bound at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module lfcs_top_chk
    import lfcs_pkg::*;
(
    // clock, reset and apb
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [LFCS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0] pstrb,
    // sources, status and branch clocks
    input wire logic slow_rc_oscillator, slow_crystal_oscillator, ultra_slow_rc_oscillator,
    input wire logic [LFCS_STATUS_W-1:0] osc_status_live,
    input wire logic branch_a_slow_clock, branch_b_slow_clock
);
    // shadow of the select register, rebuilt from apb writes
    logic [1:0]  sa, sb;
    logic        ae, be, ea, eb, st, mp;
    logic [31:0] rb;
    // field 3 is left out: the halved core clock phase is not visible here
    function automatic logic pk(input logic [1:0] s, input logic e);
        return s == 2'h0 ? e & ultra_slow_rc_oscillator : s == 2'h1 ? slow_rc_oscillator : slow_crystal_oscillator;
    endfunction : pk
    assign st = psel && !penable;
    assign mp = paddr == LFCS_OFF_SELECT || paddr == LFCS_OFF_STATUS;
    assign rb = {11'h0, be, 3'h0, ae, 12'h0, sa, sb};
    always_comb begin
        ea = pk(sa, ae);
        eb = pk(sb, be);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sa, sb, ae, be} <= 6'h14;
        end else if (psel && penable && pready && pwrite && paddr == LFCS_OFF_SELECT) begin
            if (pstrb[0]) {sa, sb} <= pwdata[3:0];
            if (pstrb[2]) {ae, be} <= {pwdata[16], pwdata[20]};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_zero_wait: assert property (st |=> pready) else $error("no zero wait answer");
    chk_bad_addr: assert property (st && !mp |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    chk_good_addr: assert property (st && mp |=> !pslverr) else $error("mapped access refused");
    chk_err_pulse: assert property (pslverr |-> psel && penable) else $error("error outside access");
    chk_data_hold: assert property (!st |=> $stable(prdata)) else $error("read data moved");
    chk_sel_read: assert property (
        st && !pwrite && paddr == LFCS_OFF_SELECT |=> prdata == $past(rb)) else $error("select readback");
    chk_status_read: assert property (
        st && !pwrite && paddr == LFCS_OFF_STATUS && $past(presetn, 2)
        |=> prdata == {17'h0, $past(osc_status_live, 2)}) else $error("status readback");
    chk_branch_a: assert property (
        sa != 2'h3 |=> branch_a_slow_clock == $past(ea)) else $error("branch a source");
    chk_branch_b: assert property (
        sb != 2'h3 |=> branch_b_slow_clock == $past(eb)) else $error("branch b source");
endmodule : lfcs_top_chk
bind lfcs_top lfcs_top_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr, .paddr,
    .pwdata, .prdata, .pstrb, .slow_rc_oscillator, .slow_crystal_oscillator, .ultra_slow_rc_oscillator,
    .osc_status_live, .branch_a_slow_clock, .branch_b_slow_clock);
`default_nettype wire

// ===== verification/test_low_freq_clock_select.sv
// test_low_freq_clock_select: apb tests of lfcs_top.
// assumes the checker is bound from its own file.
`timescale 1ns/10ps
`default_nettype none
module test_low_freq_clock_select
    import lfcs_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hf = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'h0;
    logic pready, pslverr, er, branch_a_slow_clock, branch_b_slow_clock, le_core_clock = 1'b0;
    logic slow_rc_oscillator = 1'b1, slow_crystal_oscillator = 1'b0, ultra_slow_rc_oscillator = 1'b1;
    logic [14:0] osc_status_live = 15'h0403;
    int mismatches = 0, checks_done = 0;
    lfcs_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .slow_rc_oscillator, .slow_crystal_oscillator, .ultra_slow_rc_oscillator, .le_core_clock,
        .osc_status_live, .branch_a_slow_clock, .branch_b_slow_clock);
    always #25 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e, input logic x);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(n, rd, e);
        chk("err", 32'(er), 32'(x));
    endtask : rdc
    function automatic logic ex(input logic [1:0] s, input logic e);
        case (s)
            2'h0: return e & ultra_slow_rc_oscillator;
            2'h1: return slow_rc_oscillator;
            2'h2: return slow_crystal_oscillator;
            default: return hf;
        endcase
    endfunction : ex
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [1:0]  a, b;
        logic [31:0] v;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc("select", LFCS_OFF_SELECT, 32'h5, 1'b0);
        rdc("status", LFCS_OFF_STATUS, 32'h403, 1'b0);
        $display("test reset done");
        // both source polarities, so xtal and off differ on one pass
        for (int p = 0; p < 2; p++) begin
            {slow_rc_oscillator, slow_crystal_oscillator, ultra_slow_rc_oscillator} <= p ? 3'b010 : 3'b101;
            for (int k = 0; k < 8; k++) begin
                a = 2'(k);
                b = 2'h3 - a;
                v = {11'h0, ~k[2], 3'h0, k[2], 12'h0, a, b};
                apb(1'b1, LFCS_OFF_SELECT, v | 32'hFFEE_FFF0, 4'hF);
                le_core_clock <= 1'b1;
                repeat (2) @(posedge pclk);
                le_core_clock <= 1'b0;
                hf = ~hf;
                repeat (3) @(posedge pclk);
                chk("clk a", 32'(branch_a_slow_clock), 32'(ex(a, k[2])));
                chk("clk b", 32'(branch_b_slow_clock), 32'(ex(b, ~k[2])));
                rdc("select", LFCS_OFF_SELECT, v, 1'b0);
            end
        end
        $display("test sources done");
        // lane 2 alone: fields must hold
        apb(1'b1, LFCS_OFF_SELECT, 32'h0011_0000, 4'h4);
        rdc("strobe", LFCS_OFF_SELECT, 32'h0011_000C, 1'b0);
        $display("test strobe done");
        apb(1'b1, LFCS_OFF_STATUS, 32'hFFFF_FFFF, 4'hF);
        chk("ro werr", 32'(er), 32'h0);
        osc_status_live <= 15'h5A3C;
        repeat (2) @(posedge pclk);
        rdc("status", LFCS_OFF_STATUS, 32'h5A3C, 1'b0);
        $display("test status done");
        apb(1'b1, 12'h030, 32'h0, 4'hF);
        chk("werr", 32'(er), 32'h1);
        rdc("unmapped", 12'h030, 32'h0, 1'b1);
        rdc("select", LFCS_OFF_SELECT, 32'h0011_000C, 1'b0);
        $display("test unmapped done");
        // reset in mid-run: the select fields fall back to their reset values
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("reset select", LFCS_OFF_SELECT, 32'h5, 1'b0);
        $display("test mid reset done");
        results();
    end
    initial begin
        repeat (4000) @(posedge pclk);
        mismatches++;
        results();
    end
endmodule : test_low_freq_clock_select
`default_nettype wire
